// ---- core/spi_port_consts.vh ----
`ifndef SPI_PORT_CONSTS_VH
`define SPI_PORT_CONSTS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define SPI_STATUS_ADDR 32'hffff0a00
`define SPI_RX_ADDR 32'hffff0a04
`define SPI_TX_ADDR 32'hffff0a08
`define SPI_DIV_ADDR 32'hffff0a0c
`define SPI_CTRL_ADDR 32'hffff0a10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPI_STATUS_RESET 32'h00000000
`define SPI_DIV_RESET 8'h1b
`define SPI_CTRL_RESET 16'h0000

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_ENABLE 0
`define CTL_MASTER 1
`define CTL_CPOL 2
`define CTL_CPHA 3
`define CTL_TX_FLUSH 4
`define CTL_RX_FLUSH 5

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define STA_TX_CNT_LSB 1
`define STA_UNDERFLOW 4
`define STA_OVERFLOW 7
`define STA_RX_CNT_LSB 8

// ----------------------------------------------------------------
// Framing and timing
// ----------------------------------------------------------------
`define BYTE_BITS 4'd8
`define LAST_BIT 3'd7
`define LAST_HALF_PERIOD 4'd15
`define MAX_BIT_RATE_HZ 5120000
`define CORE_CLK_HZ 50000000

`endif

// ---- core/spi_master_slave_port.v ----
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "spi_port_consts.vh"
// Contract
// RULE1 - Full duplex byte exchange up to 5.12 Mb
// RULE2 - Software selects master or slave operation
// RULE3 - MISO input as master, output as slave
// RULE4 - Eight-bit units, most significant bit first
// RULE5 - MOSI output as master, input as slave
// RULE6 - One byte per eight serial clocks
// RULE7 - Serial clock driven as master, received as slave
// RULE8 - Clock rate is core over 2(1+divider)
// RULE9 - Master clock polarity and phase from control
// RULE10 - Slave receives external master using configured mode
// RULE11 - Launch one edge, sample the opposite edge
// RULE12 - Slave transfer spans select low period
// RULE13 - External master holds select low during transfer
// RULE14 - Master drives select low for transfer
// RULE15 - Software routes the four pins via port0
// RULE16 - Port0 select b write needs key writes
// RULE17 - FIFO occupancy shown as counts zero to four
// RULE18 - Receive overflow flag, cleared by status read
// RULE19 - Transmit underflow flag, cleared by status read
// RULE20 - Write-only divider resetting to 0x1b
// RULE21 - Slave select and clock pass synchronisers
// RULE22 - Early select release discards partial byte

module spi_master_slave_port #(
   parameter FIFO_DEPTH = 4,
   parameter PTR_W = 2,
   parameter CNT_W = 3
) (
   input wire core_clk,
   input wire rst,
   input wire [31:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   input wire sclk_in,
   output wire sclk_out,
   output wire sclk_oe_n,
   input wire mosi_in,
   output wire mosi_out,
   output wire mosi_oe_n,
   input wire miso_in,
   output wire miso_out,
   output wire miso_oe_n,
   input wire select_pin_in,
   output wire select_pin_out,
   output wire select_pin_oe_n
);

   // ----------------------------------------------------------------
   // Configuration
   // ----------------------------------------------------------------
   localparam [1:0] M_IDLE = 2'd0;
   localparam [1:0] M_RUN = 2'd1;
   localparam [1:0] M_STOP = 2'd2;
   localparam [CNT_W-1:0] FULL_CNT = FIFO_DEPTH[CNT_W-1:0];
   reg [15:0] ctrl_q;
   reg [7:0] div_q;
   wire enable = ctrl_q[`CTL_ENABLE];
   wire is_master = enable & ctrl_q[`CTL_MASTER];
   wire is_slave = enable & ~ctrl_q[`CTL_MASTER];
   wire cpol = ctrl_q[`CTL_CPOL];
   wire cpha = ctrl_q[`CTL_CPHA];
   wire ctrl_wr = wr & (addr == `SPI_CTRL_ADDR);
   wire tx_flush = ctrl_wr & wdata[`CTL_TX_FLUSH];
   wire rx_flush = ctrl_wr & wdata[`CTL_RX_FLUSH];
   wire status_rd = rd & (addr == `SPI_STATUS_ADDR);
   wire rx_rd = rd & (addr == `SPI_RX_ADDR);
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `SPI_CTRL_RESET;
         div_q <= `SPI_DIV_RESET; // RULE20
      end else begin
         // Flush bits act once and never stay set
         if (ctrl_wr) begin
            ctrl_q <= wdata[15:0] & ~(16'h0001 << `CTL_TX_FLUSH) & ~(16'h0001 << `CTL_RX_FLUSH);
         end
         if (wr & (addr == `SPI_DIV_ADDR)) begin
            div_q <= wdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Slave input synchronisers
   // ----------------------------------------------------------------
   reg sel_s1_q, sel_s2_q, sel_s3_q;
   reg sclk_s1_q, sclk_s2_q, sclk_s3_q;
   reg mosi_s1_q, mosi_s2_q;
   // MOSI gets the same two-stage delay so data stays aligned to the clock edge
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sel_s1_q <= 1'b1;
         sel_s2_q <= 1'b1;
         sel_s3_q <= 1'b1;
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         mosi_s1_q <= 1'b0;
         mosi_s2_q <= 1'b0;
      end else begin
         sel_s1_q <= select_pin_in; // RULE21
         sel_s2_q <= sel_s1_q;
         sel_s3_q <= sel_s2_q;
         sclk_s1_q <= sclk_in; // RULE21
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         mosi_s1_q <= mosi_in;
         mosi_s2_q <= mosi_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // FIFO storage
   // ----------------------------------------------------------------
   reg [7:0] tx_mem [0:FIFO_DEPTH-1];
   reg [7:0] rx_mem [0:FIFO_DEPTH-1];
   reg [PTR_W-1:0] tx_rd_q, tx_wr_q, rx_rd_q, rx_wr_q;
   reg [CNT_W-1:0] tx_cnt_q, rx_cnt_q;
   wire tx_empty = (tx_cnt_q == {CNT_W{1'b0}});
   wire rx_empty = (rx_cnt_q == {CNT_W{1'b0}});
   wire rx_full = (rx_cnt_q == FULL_CNT);
   // Writes to a full transmit FIFO are dropped
   wire tx_push = wr & (addr == `SPI_TX_ADDR) & (tx_cnt_q != FULL_CNT);
   wire rx_pop = rx_rd & ~rx_empty;

   // ----------------------------------------------------------------
   // Master clock generator and select
   // ----------------------------------------------------------------
   reg [1:0] m_state_q;
   reg [7:0] div_cnt_q;
   reg [3:0] half_cnt_q;
   reg sck_q, sel_q;
   wire tick = (div_cnt_q == div_q);
   wire m_tick_run = is_master & (m_state_q == M_RUN) & tick;
   wire m_lead = (sck_q == cpol);
   wire start_m = is_master & (m_state_q == M_IDLE) & ~tx_empty;
   wire m_finish = m_tick_run & (half_cnt_q == `LAST_HALF_PERIOD) & tx_empty;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         m_state_q <= M_IDLE;
         div_cnt_q <= 8'h00;
         half_cnt_q <= 4'h0;
         sck_q <= 1'b0;
         sel_q <= 1'b1;
      end else if (!is_master) begin
         m_state_q <= M_IDLE;
         div_cnt_q <= 8'h00;
         half_cnt_q <= 4'h0;
         sck_q <= cpol;
         sel_q <= 1'b1;
      end else begin
         // One tick per (1 + divider) cycles: each tick is half a serial period
         div_cnt_q <= tick ? 8'h00 : div_cnt_q + 8'h01; // RULE8
         case (m_state_q)
            M_IDLE: begin
               sck_q <= cpol; // RULE9
               div_cnt_q <= 8'h00;
               half_cnt_q <= 4'h0;
               if (start_m) begin
                  sel_q <= 1'b0; // RULE14
                  m_state_q <= M_RUN;
               end
            end
            M_RUN: begin
               if (tick) begin
                  sck_q <= ~sck_q;
                  half_cnt_q <= half_cnt_q + 4'h1; // RULE6
                  if (m_finish) begin
                     m_state_q <= M_STOP;
                  end
               end
            end
            M_STOP: begin
               // Hold select for one more half period after the last edge
               if (tick) begin
                  sel_q <= 1'b1; // RULE14
                  m_state_q <= M_IDLE;
               end
            end
            default: begin
               m_state_q <= M_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Shared shift engine
   // ----------------------------------------------------------------
   wire s_start = is_slave & sel_s3_q & ~sel_s2_q; // RULE12
   wire s_end = is_slave & ~sel_s3_q & sel_s2_q;
   wire s_edge = is_slave & ~sel_s2_q & ~s_start & (sclk_s2_q != sclk_s3_q);
   wire s_lead = (sclk_s2_q != cpol); // RULE10
   wire edge_lead = is_master ? (m_tick_run & m_lead) : (s_edge & s_lead);
   wire edge_trail = is_master ? (m_tick_run & ~m_lead) : (s_edge & ~s_lead);
   // Phase 0 presents data before the first edge; phase 1 on the leading edge
   wire sample = cpha ? edge_trail : edge_lead; // RULE11
   wire launch = (cpha ? edge_lead : (edge_trail & ~m_finish))
                 | ((start_m | s_start) & ~cpha); // RULE11
   reg [3:0] launch_cnt_q;
   reg [2:0] sample_cnt_q;
   reg [7:0] tx_sh_q, rx_sh_q;
   reg out_q;
   reg under_q, over_q;
   wire load = launch & (launch_cnt_q == `BYTE_BITS);
   wire tx_pop = load & ~tx_empty;
   wire [7:0] next_byte = tx_empty ? 8'h00 : tx_mem[tx_rd_q];
   wire din = is_master ? miso_in : mosi_s2_q; // RULE3 RULE5
   wire rx_push_req = sample & (sample_cnt_q == `LAST_BIT);
   wire rx_push = rx_push_req & ~rx_full;
   wire [7:0] rx_byte = {rx_sh_q[6:0], din}; // RULE4
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         launch_cnt_q <= `BYTE_BITS;
         sample_cnt_q <= 3'd0;
         tx_sh_q <= 8'h00;
         rx_sh_q <= 8'h00;
         out_q <= 1'b0;
      end else begin
         // Early release drops the partial byte
         if (start_m | s_start | s_end) begin
            launch_cnt_q <= `BYTE_BITS; // RULE22
            sample_cnt_q <= 3'd0; // RULE22
         end
         if (launch) begin
            if (load) begin
               out_q <= next_byte[7]; // RULE4
               tx_sh_q <= {next_byte[6:0], 1'b0};
               launch_cnt_q <= 4'd1;
            end else begin
               out_q <= tx_sh_q[7];
               tx_sh_q <= {tx_sh_q[6:0], 1'b0};
               launch_cnt_q <= launch_cnt_q + 4'd1;
            end
         end
         if (sample) begin
            rx_sh_q <= rx_byte; // RULE1
            sample_cnt_q <= sample_cnt_q + 3'd1; // RULE6
         end
      end
   end

   // ----------------------------------------------------------------
   // FIFO pointers and status flags
   // ----------------------------------------------------------------
   // Pointers wrap naturally, so FIFO_DEPTH must be a power of two
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_rd_q <= {PTR_W{1'b0}};
         tx_wr_q <= {PTR_W{1'b0}};
         tx_cnt_q <= {CNT_W{1'b0}};
         rx_rd_q <= {PTR_W{1'b0}};
         rx_wr_q <= {PTR_W{1'b0}};
         rx_cnt_q <= {CNT_W{1'b0}};
         under_q <= 1'b0;
         over_q <= 1'b0;
      end else begin
         if (tx_flush) begin
            tx_rd_q <= {PTR_W{1'b0}};
            tx_wr_q <= {PTR_W{1'b0}};
            tx_cnt_q <= {CNT_W{1'b0}};
         end else begin
            if (tx_push) begin
               tx_mem[tx_wr_q] <= wdata[7:0];
               tx_wr_q <= tx_wr_q + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            if (tx_pop) begin
               tx_rd_q <= tx_rd_q + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            if (tx_push & ~tx_pop) begin
               tx_cnt_q <= tx_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // RULE17
            end else if (tx_pop & ~tx_push) begin
               tx_cnt_q <= tx_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1}; // RULE17
            end
         end
         if (rx_flush) begin
            rx_rd_q <= {PTR_W{1'b0}};
            rx_wr_q <= {PTR_W{1'b0}};
            rx_cnt_q <= {CNT_W{1'b0}};
         end else begin
            if (rx_push) begin
               rx_mem[rx_wr_q] <= rx_byte;
               rx_wr_q <= rx_wr_q + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            if (rx_pop) begin
               rx_rd_q <= rx_rd_q + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            if (rx_push & ~rx_pop) begin
               rx_cnt_q <= rx_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // RULE17
            end else if (rx_pop & ~rx_push) begin
               rx_cnt_q <= rx_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1}; // RULE17
            end
         end
         // A new event beats a status read in the same cycle
         under_q <= (load & tx_empty) | (under_q & ~status_rd); // RULE19
         over_q <= (rx_push_req & rx_full) | (over_q & ~status_rd); // RULE18
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h00000000;
      end else begin
         rdata <= 32'h00000000;
         if (status_rd) begin
            rdata <= `SPI_STATUS_RESET
                     | ({{(32-CNT_W){1'b0}}, rx_cnt_q} << `STA_RX_CNT_LSB)
                     | ({31'h00000000, over_q} << `STA_OVERFLOW)
                     | ({31'h00000000, under_q} << `STA_UNDERFLOW)
                     | ({{(32-CNT_W){1'b0}}, tx_cnt_q} << `STA_TX_CNT_LSB); // RULE17
         end else if (rx_rd) begin
            rdata <= {24'h000000, rx_empty ? 8'h00 : rx_mem[rx_rd_q]};
         end else if (rd & (addr == `SPI_CTRL_ADDR)) begin
            rdata <= {16'h0000, ctrl_q};
         end
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   assign sclk_out = sck_q;
   assign sclk_oe_n = ~is_master; // RULE7 RULE2
   assign mosi_out = out_q;
   assign mosi_oe_n = ~is_master; // RULE5
   assign miso_out = out_q;
   // Slave drives MISO only while selected so several slaves can share it
   assign miso_oe_n = ~(is_slave & ~sel_s2_q); // RULE3
   assign select_pin_out = sel_q;
   assign select_pin_oe_n = ~is_master; // RULE14

endmodule

// ---- verif/spi_far_end_model.sv ----
`timescale 1ns/1ps
module spi_far_end_model (
   input wire sclk,
   input wire select_n,
   input wire mosi,
   input wire cpol,
   input wire cpha,
   input wire [7:0] reply,
   output logic miso,
   output logic [7:0] got
);
   logic [7:0] sh;
   logic [3:0] n;
   initial begin
      miso = 1'b0;
      got = 8'h00;
      sh = 8'h00;
      n = 4'd0;
   end
   // Released line shows the inverse so that a stale sample cannot pass
   always @(posedge select_n) miso = ~miso;
   always @(negedge select_n) begin
      sh = reply;
      n = 4'd0;
      if (!cpha) miso = sh[7];
   end
   always @(sclk) begin
      if (!select_n && ((sclk != cpol) ^ cpha)) begin
         got = {got[6:0], mosi};
         n = n + 4'd1;
      end else if (!select_n) begin
         if (n == 4'd8) begin
            n = 4'd0;
            sh = reply;
         end else if (!cpha) sh = sh << 1;
         miso = sh[7];
         if (cpha) sh = sh << 1;
      end
   end
endmodule

// ---- verif/spi_master_slave_port_monitor.sv ----
`timescale 1ns/1ps
`include "spi_port_consts.vh"
module spi_port_monitor (
   input wire core_clk,
   input wire rst,
   input wire [31:0] addr,
   input wire wr,
   input wire rd,
   input wire [31:0] rdata,
   input wire sclk_out,
   input wire sclk_oe_n,
   input wire mosi_out,
   input wire mosi_oe_n,
   input wire miso_oe_n,
   input wire select_pin_out,
   input wire select_pin_oe_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic [7:0] edges_q;
   logic sck_q;
   // Clock edges within one select-low stretch, seen one cycle late
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         edges_q <= 8'h00;
         sck_q <= 1'b0;
      end else begin
         sck_q <= sclk_out;
         if (select_pin_out) edges_q <= 8'h00;
         else if (sck_q != sclk_out) edges_q <= edges_q + 8'h01;
      end
   end
   chk_status_counts:
   assert property ($past(rd) && $past(addr) == `SPI_STATUS_ADDR
      |-> rdata[10:8] <= 3'd4 && rdata[3:1] <= 3'd4) else $error("status count above four");
   chk_divider_hidden:
   assert property ($past(rd) && $past(addr) == `SPI_DIV_ADDR |-> rdata == 32'h0)
      else $error("divider register readable");
   chk_master_pins:
   assert property (sclk_oe_n == mosi_oe_n && mosi_oe_n == select_pin_oe_n)
      else $error("master pin enables disagree");
   chk_slave_out:
   assert property (!miso_oe_n |-> mosi_oe_n && sclk_oe_n) else $error("miso driven as master");
   chk_select_master:
   assert property ($fell(select_pin_out) |-> !sclk_oe_n) else $error("select low while not master");
   chk_clock_quiet:
   assert property (select_pin_out && $past(select_pin_out) && !$past(wr) && !$past(wr, 2)
      |-> $stable(sclk_out)) else $error("serial clock moves outside frame");
   chk_mosi_on_edge:
   assert property (!mosi_oe_n && !select_pin_out && !$past(select_pin_out) && $changed(mosi_out)
      |-> $changed(sclk_out)) else $error("mosi changes off a clock edge");
   chk_whole_bytes:
   assert property ($rose(select_pin_out) |-> edges_q[3:0] == 4'h0 && edges_q != 8'h00)
      else $error("frame not whole bytes");
   cover property ($fell(select_pin_out));
   cover property ($past(rd) && $past(addr) == `SPI_STATUS_ADDR && rdata[7]);
   cover property ($past(rd) && $past(addr) == `SPI_STATUS_ADDR && rdata[4]);
   cover property (!miso_oe_n);
endmodule
bind spi_master_slave_port spi_port_monitor mon (.core_clk(core_clk), .rst(rst), .addr(addr),
   .wr(wr), .rd(rd), .rdata(rdata), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
   .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n),
   .select_pin_out(select_pin_out), .select_pin_oe_n(select_pin_oe_n));

// ---- verif/spi_master_slave_port_tb_top.sv ----
`timescale 1ns/1ps
`include "spi_port_consts.vh"
module spi_master_slave_port_tb_top;
   logic core_clk, rst, wr, rd, m_sclk, m_mosi, m_sel, cpol, cpha, fm_miso;
   logic sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, sel_out, sel_oe_n;
   logic [31:0] addr, wdata, rdata, rd_val;
   logic [7:0] reply, got, seen;
   int mismatches, total_checks, cycles, n;
   typedef struct {logic [3:0] mode; logic [7:0] div; logic [7:0] tx; logic [7:0] rx;} row_t;
   row_t rows[4] = '{'{4'h3, 8'h00, 8'ha5, 8'h3c}, '{4'h7, 8'h01, 8'h81, 8'h7e},
      '{4'hb, 8'h02, 8'h5a, 8'hc3}, '{4'hf, 8'h03, 8'h01, 8'h80}};
   // Each pin level comes from whichever side has it enabled
   // Direct wiring stands for the port0 routing that software unlocks and sets
   wire sck_w = sclk_oe_n ? m_sclk : sclk_out;
   wire mosi_w = mosi_oe_n ? m_mosi : mosi_out;
   wire sel_w = sel_oe_n ? m_sel : sel_out;
   wire miso_w = miso_oe_n ? fm_miso : miso_out;
   spi_master_slave_port DUT (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .sclk_in(sck_w), .sclk_out(sclk_out),
      .sclk_oe_n(sclk_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
      .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .select_pin_in(sel_w),
      .select_pin_out(sel_out), .select_pin_oe_n(sel_oe_n));
   spi_far_end_model far (.sclk(sck_w), .select_n(sel_w), .mosi(mosi_w), .cpol(cpol),
      .cpha(cpha), .reply(reply), .miso(fm_miso), .got(got));
   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] act);
      total_checks++;
      if (act !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, act);
      end
   endtask
   task automatic step;
      @(posedge core_clk);
      #1;
   endtask
   task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   task automatic expect_rd(input string what, input logic [31:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 check(what, exp, rdata);
   endtask
   task automatic half_period(output int cnt);
      logic s;
      s = sclk_out;
      cnt = 0;
      while (sclk_out === s) step;
      s = sclk_out;
      while (sclk_out === s) begin
         step;
         cnt++;
      end
   endtask
   task automatic wait_frame;
      while (sel_out !== 1'b0) step;
      while (sel_out !== 1'b1) step;
   endtask
   // Plays an external master with the clock low for five and high for four core cycles per bit
   task automatic slave_frame(input logic [7:0] b, input int bits);
      seen = 8'h00;
      @(posedge core_clk);
      m_sel <= 1'b0;
      for (int k = 7; k > 7 - bits; k--) begin
         @(posedge core_clk);
         m_mosi <= b[k];
         repeat (4) @(posedge core_clk);
         m_sclk <= 1'b1;
         seen = {seen[6:0], miso_w};
         if (k == 7) check("miso enable", 32'h0, {31'h0, miso_oe_n});
         repeat (4) @(posedge core_clk);
         m_sclk <= 1'b0;
      end
      repeat (4) @(posedge core_clk);
      m_sel <= 1'b1;
      m_mosi <= ~m_mosi;
      repeat (6) step;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      cycles = 0;
      forever begin
         @(posedge core_clk);
         cycles++;
         if (cycles == 20000) begin
            mismatches++;
            $display("mismatch timeout expected done seen hang");
            summarize;
         end
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 32'h0;
      wdata = 32'h0;
      m_sclk = 1'b0;
      m_mosi = 1'b0;
      m_sel = 1'b1;
      cpol = 1'b0;
      cpha = 1'b0;
      reply = 8'h96;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      expect_rd("status reset", `SPI_STATUS_ADDR, `SPI_STATUS_RESET);
      expect_rd("control reset", `SPI_CTRL_ADDR, 32'h0);
      expect_rd("divider read", `SPI_DIV_ADDR, 32'h0);
      expect_rd("tx read", `SPI_TX_ADDR, 32'h0);
      expect_rd("unmapped", 32'hffff0a14, 32'h0);
      reg_wr(`SPI_CTRL_ADDR, 32'h3);
      reg_wr(`SPI_TX_ADDR, 32'h42);
      half_period(n);
      check("default half period", 32'd28, n);
      wait_frame;
      expect_rd("default rx", `SPI_RX_ADDR, 32'h96);
      foreach (rows[i]) begin
         cpol = rows[i].mode[2];
         cpha = rows[i].mode[3];
         reply = rows[i].rx;
         reg_wr(`SPI_DIV_ADDR, {24'h0, rows[i].div});
         reg_wr(`SPI_CTRL_ADDR, {28'h0, rows[i].mode});
         repeat (3) step;
         check("clock idle", {31'h0, cpol}, {31'h0, sclk_out});
         check("master pins", 32'h8, {28'h0, miso_oe_n, sclk_oe_n, mosi_oe_n, sel_oe_n});
         reg_wr(`SPI_TX_ADDR, {24'h0, rows[i].tx});
         half_period(n);
         check("half period", {24'h0, rows[i].div} + 32'd1, n);
         wait_frame;
         check("far end byte", {24'h0, rows[i].tx}, {24'h0, got});
         expect_rd("rx byte", `SPI_RX_ADDR, {24'h0, rows[i].rx});
         expect_rd("status idle", `SPI_STATUS_ADDR, 32'h0);
      end
      // Filling while disabled keeps the transfer from draining the FIFO
      cpol = 1'b0;
      cpha = 1'b0;
      reg_wr(`SPI_CTRL_ADDR, 32'h2);
      for (int k = 0; k < 5; k++) reg_wr(`SPI_TX_ADDR, 32'h10 + k);
      expect_rd("tx full", `SPI_STATUS_ADDR, 32'h8);
      reg_wr(`SPI_CTRL_ADDR, 32'h3);
      wait_frame;
      check("last of four", 32'h13, {24'h0, got});
      expect_rd("rx full", `SPI_STATUS_ADDR, 32'h400);
      reg_wr(`SPI_TX_ADDR, 32'h20);
      wait_frame;
      expect_rd("overflow", `SPI_STATUS_ADDR, 32'h480);
      expect_rd("overflow cleared", `SPI_STATUS_ADDR, 32'h400);
      reg_wr(`SPI_CTRL_ADDR, 32'h21);
      expect_rd("control slave", `SPI_CTRL_ADDR, 32'h1);
      check("slave pins", 32'hf, {28'h0, miso_oe_n, sclk_oe_n, mosi_oe_n, sel_oe_n});
      reg_wr(`SPI_TX_ADDR, 32'hc6);
      slave_frame(8'h9b, 8);
      check("slave miso byte", 32'hc6, {24'h0, seen});
      expect_rd("slave rx", `SPI_RX_ADDR, 32'h9b);
      expect_rd("slave empty next", `SPI_STATUS_ADDR, 32'h10);
      slave_frame(8'h55, 3);
      expect_rd("early release", `SPI_STATUS_ADDR, 32'h10);
      expect_rd("underflow cleared", `SPI_STATUS_ADDR, 32'h0);
      reg_wr(`SPI_TX_ADDR, 32'h3a);
      slave_frame(8'he4, 8);
      check("slave after release", 32'h3a, {24'h0, seen});
      expect_rd("rx after release", `SPI_RX_ADDR, 32'he4);
      // Mid-run reset must bring the divider back to its default
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      expect_rd("control after reset", `SPI_CTRL_ADDR, 32'h0);
      reg_wr(`SPI_CTRL_ADDR, 32'h3);
      reg_wr(`SPI_TX_ADDR, 32'h5c);
      half_period(n);
      check("half period after reset", 32'd28, n);
      wait_frame;
      check("far end after reset", 32'h5c, {24'h0, got});
      summarize;
   end
endmodule
